// File: arg_pkg.sv
// constants shared by the assembly register gateway
package arg_pkg;
	localparam int unsigned WORD_W       = 16;
	localparam logic [15:0] IN_BASE      = 16'h05dc;
	localparam logic [15:0] OUT_BASE     = 16'h06a4;
	localparam int unsigned IN_LEN       = 8;
	localparam int unsigned OUT_LEN      = 4;
	localparam logic [5:0]  MAX_REGS     = 6'h2d;
	localparam int unsigned PN_BYTES     = 64;
	localparam logic [7:0]  EXC_ADDR     = 8'h02;
	localparam logic [7:0]  EXC_VALUE    = 8'h03;
	localparam logic [15:0] CMD_NONE     = 16'h0000;
	localparam logic [15:0] CMD_ACCUM    = 16'h0001;
	localparam logic [15:0] CMD_RELEASE  = 16'h0002;
	localparam logic [15:0] CMD_CANCEL   = 16'h0003;
	localparam logic [15:0] SPEED_RST    = 16'h0000;
	localparam logic [2:0]  OW_UP_CMD    = 3'h0;
	localparam logic [2:0]  OW_DN_CMD    = 3'h1;
	localparam logic [2:0]  OW_UP_SPEED  = 3'h2;
	localparam logic [2:0]  OW_DN_SPEED  = 3'h3;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} arg_state_type;
endpackage

// File: arg_gateway.sv
// assembly register gateway: builds virtual assembly images for three link protocols
`timescale 1ns/1ns
module arg_gateway #(
	parameter int unsigned IN_WORDS  = arg_pkg::IN_LEN,
	parameter int unsigned OUT_WORDS = arg_pkg::OUT_LEN
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        cfg_load,
	input  wire logic        cfg_flow_left_to_right,
	input  wire logic        cfg_single_zone,
	input  wire logic [15:0] left_zone_status,
	input  wire logic [15:0] right_zone_status,
	input  wire logic [15:0] left_arrival_cnt,
	input  wire logic [15:0] right_arrival_cnt,
	input  wire logic [15:0] left_departure_cnt,
	input  wire logic [15:0] right_departure_cnt,
	input  wire logic [15:0] left_motor_status,
	input  wire logic [15:0] right_motor_status,
	input  wire logic        mb_req_valid,
	input  wire logic        mb_req_write,
	input  wire logic [15:0] mb_req_start,
	input  wire logic [5:0]  mb_req_count,
	input  wire logic        mb_wr_valid,
	input  wire logic [15:0] mb_wr_data,
	output logic             mb_req_ready_q,
	output logic             mb_rsp_valid_q,
	output logic [15:0]      mb_rsp_data_q,
	output logic             mb_rsp_last_q,
	output logic             mb_rsp_done_q,
	output logic             mb_rsp_err_q,
	output logic [7:0]       mb_rsp_code_q,
	input  wire logic        eip_rd_valid,
	input  wire logic [5:0]  eip_rd_index,
	output logic [15:0]      eip_rd_data_q,
	input  wire logic        eip_wr_valid,
	input  wire logic [5:0]  eip_wr_index,
	input  wire logic [15:0] eip_wr_data,
	input  wire logic        pn_rd_valid,
	input  wire logic [5:0]  pn_rd_addr,
	output logic [7:0]       pn_rd_data_q,
	input  wire logic        pn_wr_valid,
	input  wire logic [5:0]  pn_wr_addr,
	input  wire logic [7:0]  pn_wr_data,
	output logic [15:0]      left_cmd_q,
	output logic [15:0]      right_cmd_q,
	output logic [15:0]      left_speed_q,
	output logic [15:0]      right_speed_q
);
	// ****************************************
	// image construction
	// ****************************************
	logic                    flow_ltr_q;
	logic                    single_q;
	arg_pkg::arg_state_type  state_q;
	logic [5:0]              idx_q;
	logic [5:0]              cnt_q;
	logic [7:0]              pn_hi_q;

	// upstream side chosen by flow, motor words stay physical
	function automatic logic [15:0] img_word(input logic [5:0] i);
		case (i)
			6'h00: return flow_ltr_q ? left_zone_status : right_zone_status;
			6'h01: return flow_ltr_q ? right_zone_status : left_zone_status;
			6'h02: return flow_ltr_q ? left_arrival_cnt : right_arrival_cnt;
			6'h03: return flow_ltr_q ? left_departure_cnt : right_departure_cnt;
			6'h04: return flow_ltr_q ? right_arrival_cnt : left_arrival_cnt;
			6'h05: return flow_ltr_q ? right_departure_cnt : left_departure_cnt;
			6'h06: return left_motor_status;
			6'h07: return right_motor_status;
			default: return 16'h0000;
		endcase
	endfunction

	// ****************************************
	// flow configuration
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			flow_ltr_q <= 1'b1;
			single_q   <= 1'b0;
		end
		else if (cfg_load)
		begin
			flow_ltr_q <= cfg_flow_left_to_right;
			single_q   <= cfg_single_zone;
		end
	end

	// ****************************************
	// holding register transactions
	// ****************************************
	logic req_take;
	logic start_ok;
	logic count_ok;
	assign req_take = mb_req_ready_q && mb_req_valid;
	assign start_ok = mb_req_write ? (mb_req_start == arg_pkg::OUT_BASE)
	                               : (mb_req_start == arg_pkg::IN_BASE);
	assign count_ok = (mb_req_count != 6'h00) && (mb_req_count <= arg_pkg::MAX_REGS)
	                  && (mb_req_count <= (mb_req_write ? 6'(OUT_WORDS) : 6'(IN_WORDS)));

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_q        <= arg_pkg::ST_IDLE;
			idx_q          <= 6'h00;
			cnt_q          <= 6'h00;
			mb_req_ready_q <= 1'b0;
			mb_rsp_valid_q <= 1'b0;
			mb_rsp_data_q  <= 16'h0000;
			mb_rsp_last_q  <= 1'b0;
			mb_rsp_done_q  <= 1'b0;
			mb_rsp_err_q   <= 1'b0;
			mb_rsp_code_q  <= 8'h00;
		end
		else
		begin
			mb_rsp_valid_q <= 1'b0;
			mb_rsp_last_q  <= 1'b0;
			mb_rsp_done_q  <= 1'b0;
			mb_rsp_err_q   <= 1'b0;
			case (state_q)
				arg_pkg::ST_IDLE:
				begin
					mb_req_ready_q <= 1'b1;
					if (req_take)
					begin
						idx_q <= 6'h00;
						cnt_q <= mb_req_count;
						if (!start_ok)
						begin
							mb_rsp_err_q  <= 1'b1;
							mb_rsp_code_q <= arg_pkg::EXC_ADDR;
						end
						else if (!count_ok)
						begin
							mb_rsp_err_q  <= 1'b1;
							mb_rsp_code_q <= arg_pkg::EXC_VALUE;
						end
						else
						begin
							mb_req_ready_q <= 1'b0;
							state_q <= mb_req_write ? arg_pkg::ST_WRITE : arg_pkg::ST_READ;
						end
					end
				end
				arg_pkg::ST_READ:
				begin
					mb_rsp_valid_q <= 1'b1;
					mb_rsp_data_q  <= img_word(idx_q);
					idx_q          <= idx_q + 6'h01;
					if (idx_q + 6'h01 == cnt_q)
					begin
						mb_rsp_last_q  <= 1'b1;
						mb_req_ready_q <= 1'b1;
						state_q        <= arg_pkg::ST_IDLE;
					end
				end
				arg_pkg::ST_WRITE:
				begin
					if (mb_wr_valid)
					begin
						idx_q <= idx_q + 6'h01;
						if (idx_q + 6'h01 == cnt_q)
						begin
							mb_rsp_done_q  <= 1'b1;
							mb_req_ready_q <= 1'b1;
							state_q        <= arg_pkg::ST_IDLE;
						end
					end
				end
				default: state_q <= arg_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// word and byte image access
	// ****************************************
	logic [15:0] pn_rd_word;
	always_comb
	begin
		pn_rd_word = img_word({1'b0, pn_rd_addr[5:1]});
	end
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			eip_rd_data_q <= 16'h0000;
			pn_rd_data_q  <= 8'h00;
			pn_hi_q       <= 8'h00;
		end
		else
		begin
			if (eip_rd_valid)
			begin
				eip_rd_data_q <= img_word(eip_rd_index);
			end
			if (pn_rd_valid)
			begin
				pn_rd_data_q <= pn_rd_addr[0] ? pn_rd_word[7:0] : pn_rd_word[15:8];
			end
			if (pn_wr_valid && !pn_wr_addr[0])
			begin
				pn_hi_q <= pn_wr_data;
			end
		end
	end

	// ****************************************
	// output image into zone control registers
	// ****************************************
	logic        ow_en;
	logic [5:0]  ow_idx;
	logic [15:0] ow_data;
	always_comb
	begin
		ow_en   = 1'b0;
		ow_idx  = 6'h00;
		ow_data = 16'h0000;
		if (state_q == arg_pkg::ST_WRITE && mb_wr_valid)
		begin
			ow_en   = 1'b1;
			ow_idx  = idx_q;
			ow_data = mb_wr_data;
		end
		else if (eip_wr_valid)
		begin
			ow_en   = 1'b1;
			ow_idx  = eip_wr_index;
			ow_data = eip_wr_data;
		end
		else if (pn_wr_valid && pn_wr_addr[0])
		begin
			ow_en   = 1'b1;
			ow_idx  = {1'b0, pn_wr_addr[5:1]};
			ow_data = {pn_hi_q, pn_wr_data};
		end
	end

	logic dn_ok;
	assign dn_ok = !single_q;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			left_cmd_q    <= arg_pkg::CMD_NONE;
			right_cmd_q   <= arg_pkg::CMD_NONE;
			left_speed_q  <= arg_pkg::SPEED_RST;
			right_speed_q <= arg_pkg::SPEED_RST;
		end
		else if (ow_en && ow_idx < 6'(OUT_WORDS))
		begin
			case (ow_idx[2:0])
				arg_pkg::OW_UP_CMD:
					if (flow_ltr_q) left_cmd_q <= ow_data; else right_cmd_q <= ow_data;
				arg_pkg::OW_DN_CMD:
					if (dn_ok && flow_ltr_q) right_cmd_q <= ow_data;
					else if (dn_ok) left_cmd_q <= ow_data;
				arg_pkg::OW_UP_SPEED:
					if (flow_ltr_q) left_speed_q <= ow_data; else right_speed_q <= ow_data;
				arg_pkg::OW_DN_SPEED:
					if (dn_ok && flow_ltr_q) right_speed_q <= ow_data;
					else if (dn_ok) left_speed_q <= ow_data;
				default:
					left_cmd_q <= left_cmd_q;
			endcase
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_bad_start;
		req_take && !start_ok;
	endsequence
	sequence s_err_answer;
		mb_rsp_err_q && mb_rsp_code_q == arg_pkg::EXC_ADDR && !mb_rsp_valid_q;
	endsequence

	a_misalign_error: assert property (s_bad_start |=> s_err_answer)
		else $error("misaligned start not answered with address exception");
	a_err_no_data: assert property (
		s_bad_start |=> (state_q == arg_pkg::ST_IDLE && !mb_rsp_valid_q) [*2])
		else $error("data moved after error");
	a_too_many_regs: assert property (
		req_take && start_ok && mb_req_count > arg_pkg::MAX_REGS |=> mb_rsp_err_q)
		else $error("oversize request accepted");
	a_read_word_img: assert property (
		state_q == arg_pkg::ST_READ
		|=> mb_rsp_valid_q && mb_rsp_data_q == $past(img_word(idx_q)))
		else $error("read word differs from assembled image");
	a_short_read_len: assert property (
		req_take && start_ok && count_ok && !mb_req_write && mb_req_count == 6'h01
		|=> ##1 mb_rsp_last_q ##1 !mb_rsp_valid_q)
		else $error("single register read not ended after one word");
	a_pn_byte_order: assert property (
		pn_rd_valid |=> pn_rd_data_q == ($past(pn_rd_addr[0]) ? $past(pn_rd_word[7:0])
		: $past(pn_rd_word[15:8])))
		else $error("byte image order wrong");
	a_eip_word_read: assert property (
		eip_rd_valid |=> eip_rd_data_q == $past(img_word(eip_rd_index)))
		else $error("word image read wrong");
	a_flow_up_map: assert property (
		ow_en && ow_idx == 6'h00 && flow_ltr_q |=> left_cmd_q == $past(ow_data))
		else $error("upstream command not routed by flow");
	a_single_down: assert property (
		ow_en && single_q && ow_idx == 6'h01 |=> $stable(left_cmd_q) && $stable(right_cmd_q))
		else $error("downstream write acted in single zone");
	a_motor_phys: assert property (
		state_q == arg_pkg::ST_READ && idx_q == 6'h06
		|=> mb_rsp_data_q == $past(left_motor_status))
		else $error("motor words not tied to physical side");
endmodule

// File: arg_plc_model.sv
// partner model: networked controller on the holding register port
`timescale 1ns/1ns
module arg_plc_model (
	input  wire logic        mclk,
	input  wire logic        mb_req_ready_q,
	input  wire logic        mb_rsp_valid_q,
	input  wire logic [15:0] mb_rsp_data_q,
	input  wire logic        mb_rsp_last_q,
	input  wire logic        mb_rsp_done_q,
	input  wire logic        mb_rsp_err_q,
	output logic             mb_req_valid = 1'b0,
	output logic             mb_req_write = 1'b0,
	output logic [15:0]      mb_req_start = 16'h0000,
	output logic [5:0]       mb_req_count = 6'h00,
	output logic             mb_wr_valid = 1'b0,
	output logic [15:0]      mb_wr_data = 16'h0000
);
	logic [15:0] rq[$];
	logic [15:0] wq[$];
	bit          err;
	bit          fin;
	bit          hung = 1'b0;
	// ****************************************
	// one transaction, entered just after an edge
	// ****************************************
	task automatic xfer(input logic w, input logic [15:0] s, input logic [5:0] c);
		int n;
		int i;
		rq.delete();
		{err, fin, n, i} = '0;
		mb_req_write = w;
		mb_req_start = s;
		mb_req_count = c;
		mb_req_valid = 1'b1;
		while (mb_req_ready_q !== 1'b1 && n < 50)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
		#1 mb_req_valid = 1'b0;
		for (n = 0; n < 60 && !fin; n++)
		begin
			if (mb_rsp_err_q === 1'b1)
				{err, fin} = 2'b11;
			if (mb_rsp_valid_q === 1'b1)
				rq.push_back(mb_rsp_data_q);
			if (mb_rsp_last_q === 1'b1 || mb_rsp_done_q === 1'b1)
				fin = 1'b1;
			mb_wr_valid = w && !err && !fin && i < wq.size();
			if (mb_wr_valid)
			begin
				mb_wr_data = wq[i];
				i++;
			end
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1 mb_wr_valid = 1'b0;
		hung |= !fin;
	endtask
endmodule

// File: assembly_register_gateway_tb_top.sv
// testbench of the assembly register gateway against a reference model
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
 $display("Error %s exp %h got %h", n, e, a); end end
module assembly_register_gateway_tb_top;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cfg_load = 1'b0;
	logic        cfg_flow_left_to_right = 1'b1;
	logic        cfg_single_zone = 1'b0;
	logic [15:0] left_zone_status, right_zone_status, left_arrival_cnt, right_arrival_cnt;
	logic [15:0] left_departure_cnt, right_departure_cnt, left_motor_status, right_motor_status;
	logic        mb_req_valid, mb_req_write, mb_wr_valid, mb_req_ready_q, mb_rsp_valid_q;
	logic        mb_rsp_last_q, mb_rsp_done_q, mb_rsp_err_q;
	logic [15:0] mb_req_start, mb_wr_data, mb_rsp_data_q, eip_rd_data_q;
	logic [15:0] left_cmd_q, right_cmd_q, left_speed_q, right_speed_q;
	logic [5:0]  mb_req_count;
	logic [7:0]  mb_rsp_code_q, pn_rd_data_q;
	logic        eip_rd_valid = 1'b0, eip_wr_valid = 1'b0, pn_rd_valid = 1'b0, pn_wr_valid = 1'b0;
	logic [5:0]  eip_rd_index = '0, eip_wr_index = '0, pn_rd_addr = '0, pn_wr_addr = '0;
	logic [15:0] eip_wr_data = 16'h0000;
	logic [7:0]  pn_wr_data = 8'h00;
	logic [15:0] cmd[2] = '{16'h0000, 16'h0000};
	logic [15:0] spd[2] = '{16'h0000, 16'h0000};
	logic [15:0] cmds[4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003};
	logic [15:0] w;
	logic [31:0] seed = 32'h9a9b;
	int          n_errors = 0;
	int          tests_run = 0;

	always #5 mclk = ~mclk;
	arg_gateway uut (.*);
	arg_plc_model plc (.*);

	// ****************************************
	// reference model and shared tasks
	// ****************************************
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function automatic logic [15:0] img(int k);
		logic u;
		u = cfg_flow_left_to_right;
		case (k)
			0: return u ? left_zone_status : right_zone_status;
			1: return u ? right_zone_status : left_zone_status;
			2: return u ? left_arrival_cnt : right_arrival_cnt;
			3: return u ? left_departure_cnt : right_departure_cnt;
			4: return u ? right_arrival_cnt : left_arrival_cnt;
			5: return u ? right_departure_cnt : left_departure_cnt;
			6: return left_motor_status;
			7: return right_motor_status;
			default: return 16'h0000;
		endcase
	endfunction
	task automatic put(int k, logic [15:0] v);
		int u;
		u = cfg_flow_left_to_right ? 0 : 1;
		if (k % 2 == 1 && cfg_single_zone)
			return;
		if (k % 2 == 1)
			u = 1 - u;
		if (k >= 2)
			spd[u] = v;
		else
			cmd[u] = v;
	endtask
	task automatic rz();
		{left_zone_status, right_zone_status} = {rnd(), rnd()};
		{left_arrival_cnt, right_arrival_cnt} = {rnd(), rnd()};
		{left_departure_cnt, right_departure_cnt} = {rnd(), rnd()};
		{left_motor_status, right_motor_status} = {rnd(), rnd()};
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic mbx(logic wr, logic [15:0] s, logic [5:0] c);
		plc.xfer(wr, s, c);
		if (plc.hung)
		begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic mrd(logic [5:0] c);
		mbx(1'b0, arg_pkg::IN_BASE, c);
		`CHK("rd_n", int'(c), plc.rq.size())
		foreach (plc.rq[k]) `CHK("rd_w", img(k), plc.rq[k])
	endtask
	task automatic merr(logic wr, logic [15:0] s, logic [5:0] c, logic [7:0] code);
		mbx(wr, s, c);
		`CHK("err", 1'b1, plc.err)
		`CHK("code", code, mb_rsp_code_q)
		`CHK("err_n", 0, plc.rq.size())
	endtask
	task automatic chk_out();
		`CHK("l_cmd", cmd[0], left_cmd_q)
		`CHK("r_cmd", cmd[1], right_cmd_q)
		`CHK("l_spd", spd[0], left_speed_q)
		`CHK("r_spd", spd[1], right_speed_q)
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		rz();
		repeat (16) @(posedge mclk);
		#1 sys_rst = 1'b0;
		@(posedge mclk);
		#1 chk_out();
		for (int i = 0; i < 4; i++)
		begin
			cfg_flow_left_to_right = !i[0];
			cfg_single_zone = i == 3;
			cfg_load = 1'b1;
			@(posedge mclk);
			#1 cfg_load = 1'b0;
			rz();
			mrd(6'h08);
			for (int k = 0; k < 64; k++)
			begin
				{pn_rd_valid, pn_rd_addr, eip_rd_valid, eip_rd_index} = {1'b1, 6'(k), k < 8, 6'(k)};
				@(posedge mclk);
				#1 {pn_rd_valid, eip_rd_valid} = 2'b00;
				w = img(k / 2);
				`CHK("pn_rd", k % 2 ? w[7:0] : w[15:8], pn_rd_data_q)
				if (k < 8) `CHK("eip_rd", img(k), eip_rd_data_q)
			end
			plc.wq = '{cmds[i], cmds[3 - i], rnd(), rnd()};
			mbx(1'b1, arg_pkg::OUT_BASE, 6'h04);
			foreach (plc.wq[k]) put(k, plc.wq[k]);
			chk_out();
		end
		{eip_wr_valid, eip_wr_index, eip_wr_data} = {1'b1, 6'h00, arg_pkg::CMD_CANCEL};
		@(posedge mclk);
		#1 {eip_wr_index, eip_wr_data} = {6'h04, rnd()};
		@(posedge mclk);
		#1 eip_wr_valid = 1'b0;
		put(0, arg_pkg::CMD_CANCEL);
		w = rnd();
		{pn_wr_valid, pn_wr_addr, pn_wr_data} = {1'b1, 6'h04, w[15:8]};
		@(posedge mclk);
		#1 {pn_wr_addr, pn_wr_data} = {6'h05, w[7:0]};
		@(posedge mclk);
		#1 pn_wr_valid = 1'b0;
		put(2, w);
		chk_out();
		plc.wq = '{rnd(), rnd(), rnd(), rnd()};
		merr(1'b0, 16'h05e0, 6'h05, arg_pkg::EXC_ADDR);
		merr(1'b0, 16'h0000, 6'h01, arg_pkg::EXC_ADDR);
		merr(1'b0, 16'h05db, 6'h08, arg_pkg::EXC_ADDR);
		merr(1'b0, arg_pkg::IN_BASE, 6'h2e, arg_pkg::EXC_VALUE);
		merr(1'b0, arg_pkg::IN_BASE, 6'h00, arg_pkg::EXC_VALUE);
		merr(1'b0, arg_pkg::IN_BASE, 6'h09, arg_pkg::EXC_VALUE);
		merr(1'b1, 16'h06a5, 6'h04, arg_pkg::EXC_ADDR);
		merr(1'b1, arg_pkg::OUT_BASE, 6'h05, arg_pkg::EXC_VALUE);
		merr(1'b1, arg_pkg::IN_BASE, 6'h04, arg_pkg::EXC_ADDR);
		chk_out();
		mrd(6'h05);
		mrd(6'h01);
		plc.wq = '{arg_pkg::CMD_ACCUM, rnd()};
		mbx(1'b1, arg_pkg::OUT_BASE, 6'h02);
		foreach (plc.wq[k]) put(k, plc.wq[k]);
		chk_out();
		conclude();
	end
endmodule
